// file: hw/fault_flash_code_shutdown.sv
`timescale 1ns/1ns
module fault_flash_code_shutdown
  import fault_flash_pkg::*;
#(
  parameter longint WARN_CYC   = WARN_CYCLES,
  parameter longint TOGGLE_CYC = TOGGLE_MIN_CYC,
  parameter int     PULSE_CYC  = PULSE_CYCLES,
  parameter int     PAUSE_CYC  = PAUSE_CYCLES,
  parameter int     HALF_2HZ   = FAST_HALF_CYC
) (
  input  wire logic      CLOCK,                    // 20 MHz clock
  input  wire logic      NRST,                     // async reset, low
  input  wire logic      CE,                       // clock enable
  input  wire fault_in_s FAULTS,                   // fault causes, level
  input  wire logic      INTERNAL_DEFECT,          // device defect, level
  input  wire logic      LOCK_CONTROL_INPUT_A,     // lock command a
  input  wire logic      LOCK_CONTROL_INPUT_B,     // lock command b
  input  wire logic      ACTUATOR_IN_RANGE,        // actuator detected
  input  wire logic      GUARD_CLOSED,             // guard closed
  output logic           SAFETY_OUTPUT_A,          // safety channel a
  output logic           SAFETY_OUTPUT_B,          // safety channel b
  output logic           SECOND_DIAGNOSTIC_OUTPUT, // diagnostic, low on warning or outputs off
  output logic           RED_LED,                  // fault indicator
  output logic           YELLOW_FAST_LED,          // 2 Hz misuse flash
  output logic           YELLOW_FAST_ACTIVE,       // misuse fault held
  output logic           WARNING_ACTIVE            // warning countdown running or expired
);
  typedef struct packed {
    logic [63:0]       warn_tmr;
    logic [63:0]       tog_tmr;
    logic [31:0]       blink_tmr;
    logic              blink;
    logic              warn_expired;
    logic [FAULT_W-1:0] latched;
    logic              defect;
    logic              rate_fault;
    logic              lock_prev;
    logic              primed;
    logic              opened;
    logic              outs_on;
    logic              diag;
    logic [CODE_W-1:0] code;
    logic              red_solid;
  } top_s;

  top_s st_reg, st_next;
  logic seq_led;
  logic lock_cmd;
  logic [FAULT_W-1:0] fv;
  logic [FAULT_W-1:0] warn_mask;
  logic [FAULT_W-1:0] hard_mask;

  // lowest numbered active fault wins the display
  function automatic logic [CODE_W-1:0] pick_code(input logic [FAULT_W-1:0] v);
    logic [CODE_W-1:0] c;
    c = '0;
    for (int i = FAULT_W - 1; i >= 0; i--) begin
      if (v[i]) c = CODE_W'(i + 1);
    end
    return c;
  endfunction : pick_code

  assign lock_cmd = LOCK_CONTROL_INPUT_A & LOCK_CONTROL_INPUT_B;
  // bit i = fault code i+1
  assign fv = {FAULTS.supply_bad, FAULTS.bolt_blocked, FAULTS.detect_fail, FAULTS.ctrl_invalid,
               FAULTS.actuator_bad, FAULTS.over_temp, FAULTS.cross_short, FAULTS.out_b_test,
               FAULTS.out_a_test};
  assign warn_mask = 9'h00F;
  assign hard_mask = 9'h1D0;

  always_comb begin
    logic any_warn;
    logic any_hard;
    logic [FAULT_W-1:0] shown;
    any_warn = 1'b0;
    any_hard = 1'b0;
    shown    = '0;
    st_next  = st_reg;
    st_next.lock_prev  = lock_cmd;
    st_next.primed     = 1'b1;
    // hard faults latch; set wins over clear
    if (!GUARD_CLOSED) st_next.opened = 1'b1;
    if (GUARD_CLOSED && st_reg.opened) begin
      st_next.latched = fv & hard_mask;
      st_next.opened  = 1'b0;
      st_next.rate_fault = 1'b0;
    end else begin
      st_next.latched = st_reg.latched | (fv & hard_mask);
    end
    if (INTERNAL_DEFECT) st_next.defect = 1'b1;
    // toggle rate check on the lock command
    if (st_reg.tog_tmr != 64'h0) st_next.tog_tmr = st_reg.tog_tmr - 64'h1;
    // no false edge from the reset value of lock_prev
    if (st_reg.primed && (lock_cmd != st_reg.lock_prev)) begin
      if (st_reg.tog_tmr != 64'h0) st_next.rate_fault = 1'b1;
      st_next.tog_tmr = TOGGLE_CYC;
    end
    // warning countdown, self-clearing
    any_warn = |(fv & warn_mask);
    if (!any_warn) begin
      st_next.warn_tmr     = 64'h0;
      st_next.warn_expired = 1'b0;
    end else if (st_reg.warn_tmr >= WARN_CYC - 64'h1) begin
      st_next.warn_expired = 1'b1;
    end else begin
      st_next.warn_tmr = st_reg.warn_tmr + 64'h1;
    end
    // 2 Hz blink
    if (st_reg.blink_tmr == 32'h0000_0000) begin
      st_next.blink_tmr = 32'(HALF_2HZ - 1);
      st_next.blink     = ~st_reg.blink;
    end else begin
      st_next.blink_tmr = st_reg.blink_tmr - 32'h0000_0001;
    end
    if (!st_next.rate_fault) st_next.blink = 1'b0;
    any_hard = (|st_next.latched) | st_next.defect | st_next.rate_fault;
    // ctrl_invalid is neither warn nor hard: display only
    st_next.outs_on = lock_cmd & ACTUATOR_IN_RANGE & GUARD_CLOSED
                      & ~any_hard & ~st_next.warn_expired;
    st_next.diag = st_next.outs_on & ~any_warn;
    shown = st_next.latched | (fv & warn_mask) | (fv & 9'h020);
    st_next.code      = pick_code(shown);
    st_next.red_solid = st_next.defect;
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      st_reg <= '0;
    end else if (CE) begin
      st_reg <= st_next;
    end
  end

  flash_sequencer #(
    .PULSE_CYC(PULSE_CYC),
    .PAUSE_CYC(PAUSE_CYC)
  ) u_seq (
    .CLOCK(CLOCK),
    .NRST (NRST),
    .CE   (CE),
    .CODE (st_reg.code),
    .LED  (seq_led)
  );

  assign SAFETY_OUTPUT_A          = st_reg.outs_on;
  assign SAFETY_OUTPUT_B          = st_reg.outs_on;
  assign SECOND_DIAGNOSTIC_OUTPUT = st_reg.diag;
  assign RED_LED                  = st_reg.red_solid | seq_led;
  assign YELLOW_FAST_LED          = st_reg.blink;
  assign YELLOW_FAST_ACTIVE       = st_reg.rate_fault;
  assign WARNING_ACTIVE           = (st_reg.warn_tmr != 64'h0) | st_reg.warn_expired;
endmodule : fault_flash_code_shutdown

// file: hw/fault_flash_pkg.sv
// What this block does
// - a first-output test fault or stray voltage on it flashes red once per group, outputs off after 30 min.
// - a second-output test fault or stray voltage on it flashes red twice per group, outputs off after 30 min.
// - a cross short or fault on both outputs flashes red three times, outputs off after 30 min.
// - overtemperature flashes red four times and switches the outputs off only after 30 min.
// - a wrong or defective actuator flashes red five times and switches the outputs off at once.
// - an invalid lock-control or electronic release input flashes red six times and keeps the outputs on.
// - failed actuator detection flashes red seven times and switches the outputs off at once.
// - a blocked bolt drive flashes red eight times and switches the outputs off at once.
// - supply out of range flashes red nine times and switches the outputs off at once.
// - lock-control inputs toggling faster than 0.3 Hz flash yellow at 2 Hz and stop the outputs at once.
// - during a warning the outputs stay on, the diagnostic output drops, and outputs go off after 30 min.
// - unlock switches the outputs off at once; relocking with the actuator in range re-enables them.
// - a latched fault clears by guard open-then-close or power cycle once its cause is gone, a device defect by power cycle only; a warning self-clears.
package fault_flash_pkg;

  localparam int  CLK_HZ         = 20_000_000;
  localparam int  WARN_MIN       = 30;
  localparam longint WARN_CYCLES = longint'(WARN_MIN) * 60 * CLK_HZ;
  localparam int  PULSE_MS       = 250;
  localparam int  PULSE_CYCLES   = PULSE_MS * (CLK_HZ / 1000);
  localparam int  PAUSE_MS       = 1500;
  localparam int  PAUSE_CYCLES   = PAUSE_MS * (CLK_HZ / 1000);
  localparam int  FAST_HZ2       = 2;
  localparam int  FAST_HALF_CYC  = CLK_HZ / (2 * FAST_HZ2);
  // min toggle spacing for 0.3 Hz: 1/0.3 s = 10/3 s
  localparam longint TOGGLE_MIN_CYC = (longint'(CLK_HZ) * 10 + 2) / 3;
  localparam int  FAULT_W        = 9;
  localparam int  CODE_W         = 4;

  typedef struct packed {
    logic out_a_test;   // first output fault
    logic out_b_test;   // second output fault
    logic cross_short;
    logic over_temp;
    logic actuator_bad;
    logic ctrl_invalid;
    logic detect_fail;
    logic bolt_blocked;
    logic supply_bad;
  } fault_in_s;

  typedef struct packed {
    logic red;
    logic yellow_fast;
    logic yellow_fast_en;
  } led_s;

endpackage : fault_flash_pkg

// file: hw/flash_sequencer.sv
`timescale 1ns/1ns
module flash_sequencer
  import fault_flash_pkg::*;
#(
  parameter int PULSE_CYC = PULSE_CYCLES,
  parameter int PAUSE_CYC = PAUSE_CYCLES
) (
  input  wire logic              CLOCK,  // system clock
  input  wire logic              NRST,   // async reset, low
  input  wire logic              CE,     // clock enable
  input  wire logic [CODE_W-1:0] CODE,   // pulses per group, 0 = dark
  output logic                   LED     // flashing output
);
  typedef struct packed {
    logic [31:0]       tmr;
    logic [CODE_W-1:0] cnt;
    logic              on;
    logic              in_pause;
    logic              led;
  } seq_s;

  seq_s st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    if (CODE == '0) begin
      st_next = '0;
    end else if (st_reg.tmr != 32'h0000_0000) begin
      st_next.tmr = st_reg.tmr - 32'h0000_0001;
    end else if (st_reg.in_pause) begin
      st_next.in_pause = 1'b0;
      st_next.on       = 1'b1;
      st_next.cnt      = CODE;
      st_next.tmr      = 32'(PULSE_CYC - 1);
    end else if (st_reg.on) begin
      st_next.on  = 1'b0;
      st_next.cnt = st_reg.cnt - 1'b1;
      st_next.tmr = 32'(PULSE_CYC - 1);
    end else if (st_reg.cnt != '0) begin
      st_next.on  = 1'b1;
      st_next.tmr = 32'(PULSE_CYC - 1);
    end else begin
      st_next.in_pause = 1'b1;
      st_next.tmr      = 32'(PAUSE_CYC - 1);
    end
    st_next.led = st_next.on;
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      st_reg <= '{tmr: 32'h0000_0000, cnt: '0, on: 1'b0, in_pause: 1'b1, led: 1'b0};
    end else if (CE) begin
      st_reg <= st_next;
    end
  end

  assign LED = st_reg.led;
endmodule : flash_sequencer

// file: tb/fault_flash_assertions.sv
`timescale 1ns/1ns
module fault_flash_assertions
  import fault_flash_pkg::*;
#(
  parameter longint WARN_CYC = WARN_CYCLES
) (
  input wire logic      CLOCK,                    // clock
  input wire logic      NRST,                     // reset, low
  input wire logic      CE,                       // enable
  input wire fault_in_s FAULTS,                   // causes
  input wire logic      INTERNAL_DEFECT,          // defect
  input wire logic      LOCK_CONTROL_INPUT_A,     // lock a
  input wire logic      LOCK_CONTROL_INPUT_B,     // lock b
  input wire logic      SAFETY_OUTPUT_A,          // out a
  input wire logic      SAFETY_OUTPUT_B,          // out b
  input wire logic      SECOND_DIAGNOSTIC_OUTPUT, // diag
  input wire logic      RED_LED,                  // red
  input wire logic      YELLOW_FAST_LED,          // yellow
  input wire logic      YELLOW_FAST_ACTIVE,       // rate fault
  input wire logic      WARNING_ACTIVE            // warning
);
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (!NRST);
  logic hard;
  int   wcnt;
  assign hard = FAULTS.actuator_bad | FAULTS.detect_fail | FAULTS.bolt_blocked | FAULTS.supply_bad;
  // cycles spent warning with outputs still on
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) wcnt <= 0;
    else if (CE) wcnt <= (WARNING_ACTIVE && SAFETY_OUTPUT_A) ? wcnt + 1 : 0;
  end
  a_pair_equal: assert property (SAFETY_OUTPUT_A == SAFETY_OUTPUT_B)
    else $error("safety outputs differ");
  a_hard_off: assert property (CE && hard |=> !SAFETY_OUTPUT_A)
    else $error("outputs on after hard fault");
  a_unlock_off: assert property (CE && !(LOCK_CONTROL_INPUT_A && LOCK_CONTROL_INPUT_B)
    |=> !SAFETY_OUTPUT_A)
    else $error("outputs on while unlocked");
  a_defect_red: assert property (CE && INTERNAL_DEFECT |=> !SAFETY_OUTPUT_A ##1 RED_LED[*4])
    else $error("defect not shown solid");
  a_warn_diag: assert property (WARNING_ACTIVE |-> !SECOND_DIAGNOSTIC_OUTPUT)
    else $error("diag high in warning");
  a_diag_on: assert property (SECOND_DIAGNOSTIC_OUTPUT |-> SAFETY_OUTPUT_A)
    else $error("diag high with outputs off");
  a_warn_bound: assert property (wcnt <= WARN_CYC + 2)
    else $error("warning outlived its delay");
  a_warn_holds: assert property ($rose(WARNING_ACTIVE) && SAFETY_OUTPUT_A |-> SAFETY_OUTPUT_A[*8])
    else $error("outputs dropped early in warning");
  a_rate_stop: assert property ($rose(YELLOW_FAST_ACTIVE) |-> ##[0:1] !SAFETY_OUTPUT_A)
    else $error("outputs on in rate fault");
  a_yellow_rate: assert property ($rose(YELLOW_FAST_LED) && CE
    |=> (YELLOW_FAST_LED || !YELLOW_FAST_ACTIVE)[*4])
    else $error("yellow half period short");
  c_warn: cover property ($rose(WARNING_ACTIVE));
  c_rate: cover property ($rose(YELLOW_FAST_ACTIVE));
  c_hard: cover property ($fell(SAFETY_OUTPUT_A) && hard);
endmodule : fault_flash_assertions
bind fault_flash_code_shutdown fault_flash_assertions #(.WARN_CYC(WARN_CYC)) u_fault_flash_assertions (
  .CLOCK                   (CLOCK),
  .NRST                    (NRST),
  .CE                      (CE),
  .FAULTS                  (FAULTS),
  .INTERNAL_DEFECT         (INTERNAL_DEFECT),
  .LOCK_CONTROL_INPUT_A    (LOCK_CONTROL_INPUT_A),
  .LOCK_CONTROL_INPUT_B    (LOCK_CONTROL_INPUT_B),
  .SAFETY_OUTPUT_A         (SAFETY_OUTPUT_A),
  .SAFETY_OUTPUT_B         (SAFETY_OUTPUT_B),
  .SECOND_DIAGNOSTIC_OUTPUT(SECOND_DIAGNOSTIC_OUTPUT),
  .RED_LED                 (RED_LED),
  .YELLOW_FAST_LED         (YELLOW_FAST_LED),
  .YELLOW_FAST_ACTIVE      (YELLOW_FAST_ACTIVE),
  .WARNING_ACTIVE          (WARNING_ACTIVE)
);

// file: tb/plc_monitor.sv
`timescale 1ns/1ns
module plc_monitor #(
  parameter int GAP = 7
) (
  input  wire logic       clock, // clock
  input  wire logic       nrst,  // reset, low
  input  wire logic       red,   // red indicator
  output logic      [3:0] group  // pulses in last group
);
  logic [3:0] pulses;
  logic       red_q;
  int         dark;
  // a long dark spell ends a group
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pulses <= 0;
      red_q  <= 0;
      dark   <= 0;
      group  <= 0;
    end else begin
      red_q <= red;
      dark  <= red ? 0 : dark + 1;
      if (red && !red_q) pulses <= pulses + 1;
      if (dark == GAP && pulses != 0) begin
        group  <= pulses;
        pulses <= 0;
      end
    end
  end
endmodule : plc_monitor

// file: tb/tb_fault_flash_code_shutdown.sv
`timescale 1ns/1ns
module tb_fault_flash_code_shutdown;
  import fault_flash_pkg::*;
  logic       clock = 0, nrst = 0, ce = 1, defect = 0, lca = 0, lcb = 0, in_rng = 1, closed = 1;
  fault_in_s  faults = '0;
  logic       sa, sb, diag, red, yel, yel_act, warn;
  logic [3:0] grp;
  int         n_errors = 0, samples_checked = 0;
  always #25 clock = ~clock;
  fault_flash_code_shutdown #(.WARN_CYC(100), .TOGGLE_CYC(20), .PULSE_CYC(4), .PAUSE_CYC(12),
    .HALF_2HZ(5)) u_fault_flash_code_shutdown (.CLOCK(clock), .NRST(nrst), .CE(ce),
    .FAULTS(faults), .INTERNAL_DEFECT(defect), .LOCK_CONTROL_INPUT_A(lca),
    .LOCK_CONTROL_INPUT_B(lcb), .ACTUATOR_IN_RANGE(in_rng), .GUARD_CLOSED(closed),
    .SAFETY_OUTPUT_A(sa), .SAFETY_OUTPUT_B(sb), .SECOND_DIAGNOSTIC_OUTPUT(diag), .RED_LED(red),
    .YELLOW_FAST_LED(yel), .YELLOW_FAST_ACTIVE(yel_act), .WARNING_ACTIVE(warn));
  plc_monitor u_plc_monitor (.clock(clock), .nrst(nrst), .red(red), .group(grp));
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic guard_cycle;
    closed <= 0;
    cyc(3);
    closed <= 1;
    cyc(7);
  endtask : guard_cycle
  // outputs stay on for warnings and the control-input fault
  function automatic logic [7:0] exp_on(input int code);
    return (code < 5 || code == 6) ? 1 : 0;
  endfunction : exp_on
  initial begin
    int   code;
    logic yq;
    void'($urandom(32'h649e));
    cyc(6);
    nrst <= 1;
    lca  <= 1;
    lcb  <= 1;
    cyc(4);
    check(sa, 1);
    check(diag, 1);
    ce  <= 0;
    lca <= 0;
    cyc(5);
    check(sa, 1);
    lca <= 1;
    ce  <= 1;
    cyc(3);
    check(sa, 1);
    for (int i = 0; i < 12; i++) begin
      code = (i < 9) ? i + 1 : $urandom_range(9, 1);
      faults <= fault_in_s'(9'h100 >> (code - 1));
      cyc(6);
      check(sa, exp_on(code));
      check(sb, exp_on(code));
      check(warn, 8'(code < 5));
      check(diag, 8'(code == 6));
      cyc(80 + $urandom_range(8));
      if (code < 5) check(sa, 1);
      cyc(120);
      check(grp, 8'(code));
      if (code < 5) check(sa, 0);
      faults <= '0;
      guard_cycle();
      check(sa, 1);
    end
    lca <= 0;
    cyc(25);
    check(sa, 0);
    lca    <= 1;
    in_rng <= 0;
    cyc(25);
    check(sa, 0);
    in_rng <= 1;
    cyc(4);
    check(sa, 1);
    repeat (4) begin
      lca <= ~lca;
      cyc(5);
    end
    check(yel_act, 1);
    check(sa, 0);
    code = 0;
    yq = yel;
    repeat (50) begin
      cyc(1);
      code += (yel !== yq);
      yq = yel;
    end
    check(8'(code), 10);
    guard_cycle();
    check(yel_act, 0);
    defect <= 1;
    cyc(4);
    check(sa, 0);
    cyc(20);
    check(red, 1);
    defect <= 0;
    nrst   <= 0;
    cyc(6);
    nrst <= 1;
    cyc(6);
    check(sa, 1);
    complete_run();
  end
  initial begin
    cyc(20000);
    n_errors++;
    complete_run();
  end
endmodule : tb_fault_flash_code_shutdown
